// File: hdl/mbs_regs.svh
// register offsets, field positions, reset values and timing for the modbus mode controller
`ifndef MBS_REGS_SVH
`define MBS_REGS_SVH
// apb byte offsets
`define MBS_OFF_STATUS 8'h00
`define MBS_OFF_SETUP 8'h04
`define MBS_OFF_CMD 8'h08
`define MBS_OFF_MBADDR 8'h0c
// status fields
`define MBS_ST_ACTIVE 8
`define MBS_ST_BUSY 9
`define MBS_ST_MBEN 10
`define MBS_ST_DFLT 11
// command register fields and opcodes
`define MBS_CMD_OP_LSB 0
`define MBS_CMD_HI_LSB 8
`define MBS_CMD_LO_LSB 16
`define MBS_OP_ENABLE 4'h1
`define MBS_OP_DISABLE 4'h2
`define MBS_OP_RESET 4'h3
// setup word: byte one in [7:0], byte two in [15:8]
`define MBS_SU_BAUD_LSB 8
`define MBS_SU_PAR_LSB 13
`define MBS_SETUP_RST 16'h0731
`define MBS_MBEN_RST 1'b0
`define MBS_MBADDR_RST 8'h01
// line settings forced while the default-mode pin is grounded
`define MBS_BAUD_300 4'h7
`define MBS_PAR_NONE1 2'h0
// function and exception codes
`define MBS_FN_PRESET 8'h06
`define MBS_FN_COILS 8'h0f
`define MBS_EXC_FUNC 8'h01
`define MBS_EXC_ADDR 8'h02
`define MBS_EXC_VALUE 8'h03
`define MBS_EXC_BUSY 8'h06
`define MBS_EXC_FLAG 8'h80
// frame lengths, buffer depth, coil count and crc constants
`define MBS_LEN_PRESET 4'h8
`define MBS_LEN_COILS 4'ha
`define MBS_LEN_MIN 4'h4
`define MBS_RXB_DEPTH 4'ha
`define MBS_NUM_COILS 16'h0008
`define MBS_CRC_INIT 16'hffff
`define MBS_CRC_POLY 16'ha001
// calibration window after a reset
`define MBS_CAL_TIME_MS 3000
`define MBS_CLK_HZ 100000000
`endif

// File: hdl/mbs_pkg.sv
// types for the modbus mode controller
package mbs_pkg;
    // frame handling states, one-hot
    typedef enum logic [2:0] {
        MBS_IDLE = 3'b001,
        MBS_EXEC = 3'b010,
        MBS_SEND = 3'b100
    } mbs_fsm_t;

    // serial line settings handed to the uart
    typedef struct packed {
        logic [3:0] baud;
        logic [1:0] parity;
        logic any_addr;
        logic [7:0] ascii_addr;
    } mbs_line_t;

    // apb answer
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mbs_apb_t;

    // whole state of the controller
    typedef struct packed {
        mbs_fsm_t fsm;
        logic [9:0][7:0] rxb;
        logic [3:0] rcnt;
        logic [15:0] rcrc;
        logic [5:0][7:0] txb;
        logic [3:0] tlen;
        logic [3:0] tidx;
        logic [15:0] tcrc;
        logic tx_valid;
        logic [7:0] tx_data;
        logic suspend_pend;
        logic mb_en;
        logic [7:0] mb_addr;
        logic [15:0] setup;
        logic active;
        logic dflt_q;
        logic [31:0] cal;
        logic busy; // calibration window running, drives the busy pin
        logic [7:0] dout;
        mbs_line_t line;
        mbs_apb_t apb;
    } mbs_state_t;
endpackage

// File: hdl/mbs_ctrl.sv
// modbus rtu slave command handling and protocol-mode control
//
// Functional notes
// (RULE1) preset register zero suspends into ascii
// (RULE2) ascii stays until remote reset or power
// (RULE3) valid preset request echoed unchanged
// (RULE4) coil write updates all addressed coils together
// (RULE5) output bit zero is coil one, upward
// (RULE6) master sends coils frame, value high byte zero
// (RULE7) coils reply echoes start and count, fresh crc
// (RULE8) coil address beyond seven gives exception
// (RULE9) enable command stores hex address, sets enable
// (RULE10) enabled modbus becomes active only after reset
// (RULE11) grounded default pin: ascii, 300 baud, any address
// (RULE12) disable clears enable, ascii after reset
// (RULE13) unknown function gives illegal function
// (RULE14) unsupported address gives illegal data address
// (RULE15) out of range value gives illegal data value
// (RULE16) busy exception during calibration after reset
// (RULE17) ascii address independent of modbus address
// (RULE18) baud and parity apply in both protocols
// (RULE19) setup byte two bits six five pick framing
// (RULE20) setup byte two low nibble picks baud
// (RULE21) bad crc or foreign address: no reply
// (RULE22) exception reply: address, fn|80, code, crc
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "mbs_regs.svh"

module mbs_ctrl #(
    parameter int CAL_CYCLES = `MBS_CAL_TIME_MS * (`MBS_CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // received rtu frame bytes from the uart
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_END,
    // reply bytes to the uart
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_READY,
    // default-mode pin, low when grounded
    input wire logic DEFAULT_N,
    // digital outputs and mode status
    output logic [7:0] DOUT,
    output logic MODBUS_ACTIVE,
    output logic BUSY,
    // serial line settings
    output logic [3:0] BAUD_CODE,
    output logic [1:0] PARITY_SEL,
    output logic ANY_ADDR,
    output logic [7:0] ASCII_ADDR
);

    // one byte step of the modbus crc
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `MBS_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // ascii hex character to nibble, top bit flags a valid digit
    function automatic logic [4:0] hex_nib(input logic [7:0] ch);
        if (ch >= 8'h30 && ch <= 8'h39) begin
            return {1'b1, 4'(ch - 8'h30)};
        end else if (ch >= 8'h41 && ch <= 8'h46) begin
            return {1'b1, 4'(ch - 8'h37)};
        end else if (ch >= 8'h61 && ch <= 8'h66) begin
            return {1'b1, 4'(ch - 8'h57)};
        end
        return 5'h00;
    endfunction

    mbs_pkg::mbs_state_t s_r; // registered state
    mbs_pkg::mbs_state_t s_nxt; // next state
    logic reset_ev; // power-up style restart of the protocol engine
    logic [7:0] exc; // exception code, zero when none
    logic [7:0] fn; // function code of the request
    logic [15:0] start; // first coil or register
    logic [15:0] cnt; // coil count or register value
    logic [15:0] mask; // coils touched by a coil write
    logic [15:0] shv; // coil value moved to its coil positions
    logic [4:0] nh; // high address digit
    logic [4:0] nl; // low address digit
    logic [3:0] nidx; // next reply byte index

    // next-state logic
    always_comb begin
        s_nxt = s_r;
        reset_ev = 1'b0;
        exc = 8'h00;
        fn = s_r.rxb[1];
        start = {s_r.rxb[2], s_r.rxb[3]};
        cnt = {s_r.rxb[4], s_r.rxb[5]};
        mask = 16'(((17'h1 << cnt[4:0]) - 17'h1) << start[3:0]);
        shv = 16'({8'h00, s_r.rxb[7]} << start[3:0]);
        nh = hex_nib(PWDATA[`MBS_CMD_HI_LSB +: 8]);
        nl = hex_nib(PWDATA[`MBS_CMD_LO_LSB +: 8]);
        nidx = s_r.tidx + 4'h1;
        s_nxt.apb.pready = 1'b0;
        s_nxt.apb.pslverr = 1'b0;
        s_nxt.dflt_q = ~DEFAULT_N;
        // calibration countdown
        if (s_r.cal != 32'h0) begin
            s_nxt.cal = s_r.cal - 32'h1;
        end
        // apb access phase: answer one cycle after penable rises
        if (PSEL && PENABLE && !s_r.apb.pready) begin
            s_nxt.apb.pready = 1'b1;
            s_nxt.apb.prdata = 32'h0;
            if (PADDR == `MBS_OFF_STATUS) begin
                s_nxt.apb.prdata[7:0] = s_r.dout;
                s_nxt.apb.prdata[`MBS_ST_ACTIVE] = s_r.active;
                s_nxt.apb.prdata[`MBS_ST_BUSY] = s_r.busy;
                s_nxt.apb.prdata[`MBS_ST_MBEN] = s_r.mb_en;
                s_nxt.apb.prdata[`MBS_ST_DFLT] = s_r.dflt_q;
            end else if (PADDR == `MBS_OFF_SETUP) begin
                s_nxt.apb.prdata[15:0] = s_r.setup;
            end else if (PADDR == `MBS_OFF_CMD) begin
                s_nxt.apb.prdata = 32'h0;
            end else if (PADDR == `MBS_OFF_MBADDR) begin
                s_nxt.apb.prdata[7:0] = s_r.mb_addr;
            end else begin
                s_nxt.apb.pslverr = 1'b1;
            end
        end
        // writes land on the edge where pready is seen high
        if (PSEL && PENABLE && s_r.apb.pready && PWRITE) begin
            if (PADDR == `MBS_OFF_SETUP) begin
                s_nxt.setup = PWDATA[15:0]; // RULE17 RULE18
            end else if (PADDR == `MBS_OFF_CMD) begin
                if (PWDATA[`MBS_CMD_OP_LSB +: 4] == `MBS_OP_ENABLE && nh[4] && nl[4]) begin
                    s_nxt.mb_en = 1'b1; // RULE9
                    s_nxt.mb_addr = {nh[3:0], nl[3:0]}; // RULE9
                end else if (PWDATA[`MBS_CMD_OP_LSB +: 4] == `MBS_OP_DISABLE) begin
                    s_nxt.mb_en = 1'b0; // RULE12
                end else if (PWDATA[`MBS_CMD_OP_LSB +: 4] == `MBS_OP_RESET) begin
                    reset_ev = 1'b1; // RULE2 RULE10
                end
            end
        end
        // frame engine
        case (s_r.fsm)
            mbs_pkg::MBS_IDLE: begin
                // gather bytes and run the crc over the whole frame
                if (RX_VALID) begin
                    if (s_r.rcnt < `MBS_RXB_DEPTH) begin
                        s_nxt.rxb[s_r.rcnt] = RX_DATA;
                    end
                    if (s_r.rcnt != 4'hf) begin
                        s_nxt.rcnt = s_r.rcnt + 4'h1;
                    end
                    s_nxt.rcrc = crc_step(s_r.rcrc, RX_DATA);
                end
                if (RX_END) begin
                    s_nxt.fsm = mbs_pkg::MBS_EXEC;
                end
            end
            mbs_pkg::MBS_EXEC: begin
                s_nxt.fsm = mbs_pkg::MBS_IDLE;
                s_nxt.rcnt = 4'h0;
                s_nxt.rcrc = `MBS_CRC_INIT;
                // frames with bad crc or a foreign address die here silently
                if (s_r.active && s_r.rcnt >= `MBS_LEN_MIN && s_r.rcrc == 16'h0
                    && s_r.rxb[0] == s_r.mb_addr) begin // RULE21
                    s_nxt.txb[0] = s_r.rxb[0];
                    s_nxt.txb[1] = fn;
                    s_nxt.txb[2] = s_r.rxb[2];
                    s_nxt.txb[3] = s_r.rxb[3];
                    s_nxt.txb[4] = s_r.rxb[4];
                    s_nxt.txb[5] = s_r.rxb[5];
                    s_nxt.tlen = 4'h6;
                    if (s_r.cal != 32'h0) begin
                        exc = `MBS_EXC_BUSY; // RULE16
                    end else if (fn == `MBS_FN_PRESET) begin
                        if (s_r.rcnt != `MBS_LEN_PRESET) begin
                            exc = `MBS_EXC_VALUE; // RULE15
                        end else if (start != 16'h0) begin
                            exc = `MBS_EXC_ADDR; // RULE14
                        end else if (cnt != 16'h0) begin
                            exc = `MBS_EXC_VALUE; // RULE15
                        end else begin
                            s_nxt.suspend_pend = 1'b1; // RULE1 RULE3
                        end
                    end else if (fn == `MBS_FN_COILS) begin
                        if (s_r.rcnt != `MBS_LEN_COILS) begin
                            exc = `MBS_EXC_VALUE; // RULE15
                        end else if (start >= `MBS_NUM_COILS || cnt > `MBS_NUM_COILS
                                     || start + cnt > `MBS_NUM_COILS) begin
                            exc = `MBS_EXC_ADDR; // RULE8 RULE14
                        end else if (cnt == 16'h0 || s_r.rxb[6] != 8'h00) begin
                            exc = `MBS_EXC_VALUE; // RULE6 RULE15
                        end else begin
                            // value bit k drives coil start+k+1, all at once
                            s_nxt.dout = (s_r.dout & ~mask[7:0]) | (shv[7:0] & mask[7:0]); // RULE4 RULE5
                        end
                    end else begin
                        exc = `MBS_EXC_FUNC; // RULE13
                    end
                    if (exc != 8'h00) begin
                        s_nxt.txb[1] = fn | `MBS_EXC_FLAG; // RULE22
                        s_nxt.txb[2] = exc; // RULE22
                        s_nxt.tlen = 4'h3;
                    end
                    s_nxt.fsm = mbs_pkg::MBS_SEND;
                    s_nxt.tidx = 4'h0;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tx_data = s_nxt.txb[0];
                    s_nxt.tcrc = crc_step(`MBS_CRC_INIT, s_nxt.txb[0]);
                end
            end
            mbs_pkg::MBS_SEND: begin
                // reply bytes, then crc low and high; for the preset echo the fresh crc equals the request's
                if (s_r.tx_valid && TX_READY) begin
                    s_nxt.tidx = nidx;
                    if (nidx < s_r.tlen) begin
                        s_nxt.tx_data = s_r.txb[nidx[2:0]];
                        s_nxt.tcrc = crc_step(s_r.tcrc, s_r.txb[nidx[2:0]]); // RULE7
                    end else if (nidx == s_r.tlen) begin
                        s_nxt.tx_data = s_r.tcrc[7:0];
                    end else if (nidx == s_r.tlen + 4'h1) begin
                        s_nxt.tx_data = s_r.tcrc[15:8];
                    end else begin
                        s_nxt.tx_valid = 1'b0;
                        s_nxt.fsm = mbs_pkg::MBS_IDLE;
                        // suspend only once the echo has left
                        if (s_r.suspend_pend) begin
                            s_nxt.active = 1'b0; // RULE1 RULE2
                        end
                        s_nxt.suspend_pend = 1'b0;
                    end
                end
            end
            default: begin
                s_nxt.fsm = mbs_pkg::MBS_IDLE;
            end
        endcase
        // releasing the default pin restarts like a power-up
        if (s_r.dflt_q && DEFAULT_N) begin
            reset_ev = 1'b1; // RULE10 RULE12
        end
        // restart: enable takes effect only here, calibration begins
        if (reset_ev) begin
            s_nxt.active = s_nxt.mb_en; // RULE10 RULE12
            s_nxt.cal = 32'(CAL_CYCLES); // RULE16
            s_nxt.fsm = mbs_pkg::MBS_IDLE;
            s_nxt.rcnt = 4'h0;
            s_nxt.rcrc = `MBS_CRC_INIT;
            s_nxt.tx_valid = 1'b0;
            s_nxt.suspend_pend = 1'b0;
        end
        // busy flag registered so the pin comes from a flop
        s_nxt.busy = (s_nxt.cal != 32'h0); // RULE16
        // grounded default pin forces ascii at fixed settings
        if (!DEFAULT_N) begin
            s_nxt.active = 1'b0; // RULE11
            s_nxt.line.baud = `MBS_BAUD_300; // RULE11
            s_nxt.line.parity = `MBS_PAR_NONE1; // RULE11
            s_nxt.line.any_addr = 1'b1; // RULE11
        end else begin
            s_nxt.line.baud = s_nxt.setup[`MBS_SU_BAUD_LSB +: 4]; // RULE18 RULE20
            s_nxt.line.parity = s_nxt.setup[`MBS_SU_PAR_LSB +: 2]; // RULE18 RULE19
            s_nxt.line.any_addr = 1'b0;
        end
        s_nxt.line.ascii_addr = s_nxt.setup[7:0]; // RULE17
    end

    // state register, power-up values on reset
    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_r <= '0;
            s_r.fsm <= mbs_pkg::MBS_IDLE;
            s_r.rcrc <= `MBS_CRC_INIT;
            s_r.tcrc <= `MBS_CRC_INIT;
            s_r.mb_en <= `MBS_MBEN_RST;
            s_r.mb_addr <= `MBS_MBADDR_RST;
            s_r.setup <= `MBS_SETUP_RST;
            s_r.active <= `MBS_MBEN_RST; // RULE10
            s_r.cal <= 32'(CAL_CYCLES); // RULE16
            s_r.busy <= (CAL_CYCLES != 0); // RULE16
            s_r.line.baud <= 4'(`MBS_SETUP_RST >> `MBS_SU_BAUD_LSB);
            s_r.line.parity <= 2'(`MBS_SETUP_RST >> `MBS_SU_PAR_LSB);
            s_r.line.ascii_addr <= 8'(`MBS_SETUP_RST);
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign PRDATA = s_r.apb.prdata;
    assign PREADY = s_r.apb.pready;
    assign PSLVERR = s_r.apb.pslverr;
    assign TX_VALID = s_r.tx_valid;
    assign TX_DATA = s_r.tx_data;
    assign DOUT = s_r.dout;
    assign MODBUS_ACTIVE = s_r.active;
    assign BUSY = s_r.busy;
    assign BAUD_CODE = s_r.line.baud;
    assign PARITY_SEL = s_r.line.parity;
    assign ANY_ADDR = s_r.line.any_addr;
    assign ASCII_ADDR = s_r.line.ascii_addr;

endmodule // mbs_ctrl

// File: sim/mbs_ctrl_assertions.sv
// concurrent checks on the modbus mode controller ports
`timescale 1ns/1ps
module mbs_ctrl_assertions (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [7:0] PADDR,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // frames
    input wire logic RX_END,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_READY,
    // mode and outputs
    input wire logic DEFAULT_N,
    input wire logic [7:0] DOUT,
    input wire logic MODBUS_ACTIVE,
    input wire logic BUSY,
    input wire logic [3:0] BAUD_CODE,
    input wire logic [1:0] PARITY_SEL,
    input wire logic ANY_ADDR
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // first cycle of an access phase
    sequence s_acc;
        $rose(PENABLE) && PSEL;
    endsequence
    // frame end two edges back
    sequence s_end2;
        $past(RX_END, 2);
    endsequence
    a_apb_wait: assert property (s_acc |=> PREADY ##1 !PREADY)
        else $error("apb answer late or not a pulse");
    a_slverr_map: assert property (PREADY |-> PSLVERR == (PADDR > 8'h0c || PADDR[1:0] != 2'h0))
        else $error("error flag does not match map");
    a_tx_hold: assert property (TX_VALID && !TX_READY && DEFAULT_N |=> TX_VALID && $stable(TX_DATA))
        else $error("reply byte dropped while stalled");
    a_busy_reset: assert property ($fell(RST) |-> BUSY [*8])
        else $error("no busy window after reset");
    a_dflt_line: assert property (!DEFAULT_N |=> BAUD_CODE == 4'h7 && PARITY_SEL == 2'h0 && ANY_ADDR && !MODBUS_ACTIVE)
        else $error("default pin settings wrong");
    a_dflt_exit: assert property ($rose(DEFAULT_N) |-> ##[1:2] BUSY)
        else $error("no busy after default exit");
    a_tx_cause: assert property ($rose(TX_VALID) |-> s_end2)
        else $error("reply without frame end");
    a_dout_cause: assert property ($changed(DOUT) |-> s_end2)
        else $error("outputs changed without frame");
endmodule // mbs_ctrl_assertions

bind mbs_ctrl mbs_ctrl_assertions mbs_ctrl_assertions_i (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_END(RX_END),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .DEFAULT_N(DEFAULT_N),
    .DOUT(DOUT), .MODBUS_ACTIVE(MODBUS_ACTIVE), .BUSY(BUSY), .BAUD_CODE(BAUD_CODE),
    .PARITY_SEL(PARITY_SEL), .ANY_ADDR(ANY_ADDR));

// File: sim/mbs_master_model.sv
// rtu master model: sends frames with crc, collects reply bytes
`timescale 1ns/1ps
module mbs_master_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_end,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] got [$]; // reply bytes taken
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_end = 1'b0;
        tx_ready = 1'b0;
    end
    // crc-16, low byte sent first
    function automatic logic [15:0] crc(input logic [7:0] q [$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // whole frame, then gap; bad flips one crc bit
    task send(input logic [7:0] q [$], input logic bad);
        logic [15:0] c;
        c = crc(q) ^ {15'h0, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= q[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        rx_data <= ~rx_data;
        @(posedge clk);
        rx_end <= 1'b0;
    endtask
    // take up to n bytes at the accepting edge; slow stalls every other cycle
    task recv(input int n, input logic slow);
        got = {};
        for (int k = 0; k < 40 && got.size() < n; k++) begin
            @(posedge clk);
            if (tx_ready && tx_valid) got.push_back(tx_data);
            tx_ready <= (got.size() < n) && (slow ? ~tx_ready : 1'b1);
        end
    endtask
endmodule // mbs_master_model

// File: sim/mbs_ctrl_tb.sv
// self-checking bench for the modbus mode controller
`timescale 1ns/1ps
module mbs_ctrl_tb;
    logic MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RX_VALID, RX_END;
    logic TX_VALID, TX_READY, DEFAULT_N, MODBUS_ACTIVE, BUSY, ANY_ADDR;
    logic [7:0] PADDR, RX_DATA, TX_DATA, DOUT, ASCII_ADDR;
    logic [31:0] PWDATA, PRDATA, rdat;
    logic [3:0] BAUD_CODE;
    logic [1:0] PARITY_SEL;
    logic [7:0] q [$];
    logic [7:0] e [$];
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    mbs_ctrl #(.CAL_CYCLES(20)) mbs_ctrl_i (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_END(RX_END),
        .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .DEFAULT_N(DEFAULT_N),
        .DOUT(DOUT), .MODBUS_ACTIVE(MODBUS_ACTIVE), .BUSY(BUSY), .BAUD_CODE(BAUD_CODE),
        .PARITY_SEL(PARITY_SEL), .ANY_ADDR(ANY_ADDR), .ASCII_ADDR(ASCII_ADDR));
    mbs_master_model mbs_master_model_i (.clk(MCLK), .rx_valid(RX_VALID), .rx_data(RX_DATA),
        .rx_end(RX_END), .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_ready(TX_READY));
    // clock
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    // hang guard
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 6000) begin
            miscompares++;
            end_sim();
        end
    end
    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        // request held until the edge at which pready is seen high
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rdat = PRDATA;
        chk(PSLVERR, a > 8'h0c);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rdat, x);
    endtask
    // frame q out, reply compared against e plus crc
    task xfer(input logic bad, input logic slow);
        logic [15:0] c;
        if (e.size() != 0) begin
            c = mbs_master_model_i.crc(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        mbs_master_model_i.send(q, bad);
        mbs_master_model_i.recv(e.size() ? e.size() : 1, slow);
        chk(mbs_master_model_i.got.size(), e.size());
        foreach (e[i]) if (i < mbs_master_model_i.got.size()) chk(mbs_master_model_i.got[i], e[i]);
    endtask
    task exc(input logic [7:0] code);
        e = '{q[0], q[1] | 8'h80, code};
        xfer(1'b0, 1'b0);
    endtask
    logic [71:0] xt [7] = '{72'h0a0f000800010001_02, 72'h0a0f000600030007_02, 72'h0a0f000000000000_03,
        72'h0a0f000000010101_03, 72'h0a0600010000_0000_02, 72'h0a0600000005_0000_03, 72'h0a0300000001_0000_01};
    logic [3:0] bt [10] = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'h9, 4'h8};
    // main sequence
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        RST = 1'b1;
        DEFAULT_N = 1'b1;
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        rd(8'h00, 32'h200);
        rd(8'h04, 32'h731);
        rd(8'h0c, 32'h1);
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h0);
        apb(1'b1, 8'h08, 32'h0061_3001);
        rd(8'h0c, 32'h61 - 32'h57);
        repeat (25) @(posedge MCLK);
        rd(8'h00, 32'h400);
        q = '{8'h0a, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01};
        e = {};
        xfer(1'b0, 1'b0);
        apb(1'b1, 8'h08, 32'h3);
        exc(8'h06);
        $display("mode entry done");
        repeat (25) @(posedge MCLK);
        q = '{8'h0a, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h03};
        e = q[0:5];
        xfer(1'b0, 1'b1);
        chk(DOUT, 8'h03);
        q = '{8'h0a, 8'h0f, 8'h00, 8'h05, 8'h00, 8'h03, 8'h00, 8'h05};
        e = q[0:5];
        xfer(1'b0, 1'b0);
        chk(DOUT, 8'ha3);
        foreach (xt[i]) begin
            q = {};
            for (int j = 0; j < (xt[i][63:56] == 8'h0f ? 8 : 6); j++) q.push_back(xt[i][71-8*j -: 8]);
            exc(xt[i][7:0]);
            chk(DOUT, 8'ha3);
        end
        q[0] = 8'h0b;
        e = {};
        xfer(1'b0, 1'b0);
        q[0] = 8'h0a;
        xfer(1'b1, 1'b0);
        $display("coils and exceptions done");
        q = '{8'h0a, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
        e = q;
        xfer(1'b0, 1'b0);
        rd(8'h00, 32'h4a3);
        q = '{8'h0a, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        e = {};
        xfer(1'b0, 1'b0);
        apb(1'b1, 8'h08, 32'h3);
        repeat (25) @(posedge MCLK);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdat[8], 1'b1);
        $display("suspend done");
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, 8'h04, {17'h0, 2'(i), 1'b0, bt[i], 8'h32});
            repeat (2) @(negedge MCLK);
            chk({PARITY_SEL, BAUD_CODE}, {2'(i), bt[i]});
        end
        chk(ASCII_ADDR, 8'h32);
        rd(8'h0c, 32'h0a);
        DEFAULT_N <= 1'b0;
        repeat (2) @(negedge MCLK);
        chk({ANY_ADDR, MODBUS_ACTIVE, PARITY_SEL, BAUD_CODE}, 8'h87);
        xfer(1'b0, 1'b0);
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b0, 8'h00, 32'h0);
        chk(rdat[11:8], 4'h8);
        @(posedge MCLK);
        DEFAULT_N <= 1'b1;
        repeat (3) @(negedge MCLK);
        chk({MODBUS_ACTIVE, BUSY, BAUD_CODE}, 6'h18);
        $display("default pin done");
        end_sim();
    end
endmodule // mbs_ctrl_tb
